// ===== hw/cps_output_timing.sv
// Purpose: Program select, speed compensation and timed channel outputs
// Assumes: Position, speed, scale factor and setpoints come from logic
//          on ref_clk; program select pins are asynchronous
// Notes:   Setpoint storage lives outside and follows active_program
//
// Notes on behaviour
// - Flat number 1-64 derives bank and index
// - Eight banks of eight programs each
// - Energized select pins replace keyboard index
// - Select pins never change the bank
// - Serial port may change bank and index
// - Standard mode shifts both edges equally
// - Compensation held in degrees per 1000 RPM
// - Each channel has its own compensation
// - Negative value makes channel lag position
// - Negative entered only by decrement from zero
// - Negative value reads back with sign
// - Timed channel ends at dwell or off
// - Zero dwell disables timing
// - Each channel keeps its own dwell
// - Too many timed channels raises error
// - Travel per ms is RPM times 0.006 degrees
// - Six degrees per 1000 RPM is 1 ms
// - Single type uses one value both edges
// - Split type keeps lead and trail values
// - Channel settings apply to all programs
// - No pins energized runs keyboard program
`timescale 1ns/1ns

module cps_output_timing #(
  parameter int NCH       = 8,
  parameter int POSW      = 14,
  parameter int RPMW      = 14,
  parameter int MS_COUNT  = cps_pkg::MS_CYCLES
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire cps_pkg::cps_req_t    req,
  output logic [cps_pkg::DW-1:0]    rdata,
  input  wire cps_pkg::cps_ser_t    ser,
  input  wire logic [2:0]           prog_sel_pins,
  input  wire logic [POSW-1:0]      position,
  input  wire logic [POSW-1:0]      scale_factor,
  input  wire logic [RPMW-1:0]      rpm,
  input  wire logic [NCH*POSW-1:0]  on_setpoint,
  input  wire logic [NCH*POSW-1:0]  off_setpoint,
  output logic [5:0]                active_program,
  output logic [NCH-1:0]            channel_out,
  output logic                      timed_output_overflow_error
);
  import cps_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [2:0] pins_meta_q;
  logic [2:0] pins_q;

  // Select pins are asynchronous, two stages before use
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pins_meta_q <= 3'h0;
      pins_q      <= 3'h0;
    end else begin
      pins_meta_q <= prog_sel_pins;
      pins_q      <= pins_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [3:0]          program_bank_index_q;
  logic [3:0]          in_bank_program_index_q;
  cps_ctype_t          comp_type_select_q;
  logic [1:0]          dwell_time_base_q;
  logic [DW-1:0]       rdata_q;
  logic [NCH-1:0][9:0] lead_mag_q;
  logic [NCH-1:0][9:0] trail_mag_q;
  logic [NCH-1:0]      lead_neg_q;
  logic [NCH-1:0]      trail_neg_q;
  logic [NCH-1:0][DW-1:0] dwell_q;

  wire [1:0]  page      = req.addr[7:6];
  wire [3:0]  chan_idx  = req.addr[5:2];
  wire        chan_ok   = 32'(chan_idx) < NCH;
  wire        wr_flat   = req.wr && req.addr == OFS_FLAT;
  wire        wr_bank   = req.wr && req.addr == OFS_BANK;
  wire        wr_index  = req.wr && req.addr == OFS_INDEX;
  wire        wr_ctype  = req.wr && req.addr == OFS_CTYPE;
  wire        wr_tbase  = req.wr && req.addr == OFS_TBASE;
  wire        dec_key   = req.wr && req.addr == OFS_DECKEY;
  wire [3:0]  dec_chan  = req.wdata[3:0];
  wire        dec_trail = req.wdata[DEC_TRAIL];

  // Flat number split into bank and in-bank program
  wire [5:0]  flat_m1   = 6'(req.wdata[6:0] - 7'h01);
  wire        flat_ok   = req.wdata[6:0] >= 7'h01 &&
                          req.wdata[6:0] <= 7'h40;
  wire [3:0]  flat_bank = {1'b0, flat_m1[5:3]} + 4'h1;
  wire [3:0]  flat_idx  = {1'b0, flat_m1[2:0]} + 4'h1;
  wire        val18     = req.wdata[3:0] >= 4'h1 &&
                          req.wdata[3:0] <= 4'h8;
  wire        ser_ok    = ser.value >= 4'h1 && ser.value <= 4'h8;

  // ----------------------------------------------------------------
  // Program selection registers
  // ----------------------------------------------------------------
  // Register port wins a same-cycle clash with the serial port
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      program_bank_index_q    <= RST_BANK;
      in_bank_program_index_q <= RST_INDEX;
    end else if (wr_flat && flat_ok) begin
      program_bank_index_q    <= flat_bank;
      in_bank_program_index_q <= flat_idx;
    end else if (wr_bank && val18) begin
      program_bank_index_q    <= req.wdata[3:0];
    end else if (wr_index && val18) begin
      in_bank_program_index_q <= req.wdata[3:0];
    end else if (ser.wr && ser_ok) begin
      if (ser.sel_bank) begin
        program_bank_index_q    <= ser.value;
      end else begin
        in_bank_program_index_q <= ser.value;
      end
    end
  end

  // Pins override only the in-bank index, never the bank
  wire       hw_active = |pins_q;
  wire [3:0] eff_index = hw_active ? {1'b0, pins_q} + 4'h1
                                   : in_bank_program_index_q;
  wire [5:0] prog_next = 6'({program_bank_index_q[2:0] - 3'h1,
                             3'h0}) + 6'(eff_index - 4'h1);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      active_program <= 6'h00;
    end else begin
      active_program <= prog_next;
    end
  end

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      comp_type_select_q <= CPS_COMP_ONE;
      dwell_time_base_q  <= 2'h0;
    end else begin
      if (wr_ctype) begin
        comp_type_select_q <= cps_ctype_t'(req.wdata[0]);
      end
      if (wr_tbase) begin
        dwell_time_base_q <= req.wdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Millisecond tick for dwell timing
  // ----------------------------------------------------------------
  logic [23:0] ms_cnt_q;
  wire         ms_tick = ms_cnt_q == 24'(MS_COUNT - 1);

  always_ff @(posedge ref_clk) begin
    if (rst || ms_tick) begin
      ms_cnt_q <= 24'h0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 24'h1;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel compensation, dwell and output
  // ----------------------------------------------------------------
  // Channel state is indexed by channel only, so it is shared by
  // every stored program
  logic [NCH-1:0][DW-1:0] lead_rd;
  logic [NCH-1:0][DW-1:0] trail_rd;
  logic [NCH-1:0]         timed;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire sel    = chan_ok && chan_idx == 4'(g);
      wire wr_l   = req.wr && sel && page == PAGE_LEAD;
      wire wr_t   = req.wr && sel && page == PAGE_TRAIL;
      wire wr_d   = req.wr && sel && page == PAGE_DWELL;
      wire dk     = dec_key && dec_chan == 4'(g);
      wire dk_l   = dk && !dec_trail;
      wire dk_t   = dk && dec_trail;
      wire [9:0] wval = req.wdata[9:0];

      // Magnitude and sign, 1 deg/1000 RPM per count
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          lead_mag_q[g]  <= 10'h0;
          lead_neg_q[g]  <= 1'b0;
        end else if (wr_l) begin
          lead_mag_q[g]  <= wval;
          if (wval == 10'h0) begin
            lead_neg_q[g] <= 1'b0;
          end
        end else if (dk_l) begin
          if (lead_neg_q[g] || lead_mag_q[g] == 10'h0) begin
            lead_neg_q[g] <= 1'b1;
            if (lead_mag_q[g] != 10'h3FF) begin
              lead_mag_q[g] <= lead_mag_q[g] + 10'h1;
            end
          end else begin
            lead_mag_q[g] <= lead_mag_q[g] - 10'h1;
          end
        end
      end

      // Trailing value held apart for the split type
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          trail_mag_q[g] <= 10'h0;
          trail_neg_q[g] <= 1'b0;
        end else if (wr_t) begin
          trail_mag_q[g] <= wval;
          if (wval == 10'h0) begin
            trail_neg_q[g] <= 1'b0;
          end
        end else if (dk_t) begin
          if (trail_neg_q[g] || trail_mag_q[g] == 10'h0) begin
            trail_neg_q[g] <= 1'b1;
            if (trail_mag_q[g] != 10'h3FF) begin
              trail_mag_q[g] <= trail_mag_q[g] + 10'h1;
            end
          end else begin
            trail_mag_q[g] <= trail_mag_q[g] - 10'h1;
          end
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          dwell_q[g] <= 16'h0;
        end else if (wr_d) begin
          dwell_q[g] <= req.wdata;
        end
      end

      // Minus flag shows in the top read bit
      assign lead_rd[g]  = {lead_neg_q[g], 5'h0, lead_mag_q[g]};
      assign trail_rd[g] = {trail_neg_q[g], 5'h0, trail_mag_q[g]};
      assign timed[g]    = dwell_q[g] != 16'h0;

      // Single type drives both edges from the leading value
      wire       both  = comp_type_select_q == CPS_COMP_BOTH;
      wire [9:0] t_mag = both ? trail_mag_q[g] : lead_mag_q[g];
      wire       t_neg = both ? trail_neg_q[g] : lead_neg_q[g];

      // deg = comp*rpm/1000; units = deg*sf/360
      wire [63:0] l_prod = 64'(lead_mag_q[g]) * 64'(rpm) *
                           64'(scale_factor);
      wire [63:0] t_prod = 64'(t_mag) * 64'(rpm) *
                           64'(scale_factor);
      wire [63:0] div    = 64'(COMP_RPM_UNIT * DEG_PER_REV);
      wire [63:0] sfw    = (scale_factor == '0) ? 64'h1
                                                : 64'(scale_factor);
      wire [POSW-1:0] l_sh = POSW'((l_prod / div) % sfw);
      wire [POSW-1:0] t_sh = POSW'((t_prod / div) % sfw);

      // Advance reads ahead; lag reads behind, wrapped to one turn
      wire [POSW:0] p_ext = {1'b0, position};
      wire [POSW:0] s_ext = {1'b0, scale_factor};
      wire [POSW:0] l_adv = p_ext + {1'b0, l_sh};
      wire [POSW:0] t_adv = p_ext + {1'b0, t_sh};
      wire [POSW:0] l_lag = p_ext + s_ext - {1'b0, l_sh};
      wire [POSW:0] t_lag = p_ext + s_ext - {1'b0, t_sh};
      wire [POSW:0] l_raw = lead_neg_q[g] ? l_lag : l_adv;
      wire [POSW:0] t_raw = t_neg ? t_lag : t_adv;
      wire [POSW-1:0] l_pos = POSW'(l_raw >= s_ext ? l_raw - s_ext
                                                   : l_raw);
      wire [POSW-1:0] t_pos = POSW'(t_raw >= s_ext ? t_raw - s_ext
                                                   : t_raw);

      wire [POSW-1:0] on_sp  = on_setpoint[g*POSW +: POSW];
      wire [POSW-1:0] off_sp = off_setpoint[g*POSW +: POSW];
      wire wrap  = on_sp > off_sp;
      wire l_in  = wrap ? (l_pos >= on_sp || l_pos < off_sp)
                        : (l_pos >= on_sp && l_pos < off_sp);
      wire t_in  = wrap ? (t_pos >= on_sp || t_pos < off_sp)
                        : (t_pos >= on_sp && t_pos < off_sp);

      logic           l_in_q;
      logic           t_in_q;
      logic           out_q;
      logic [DW-1:0]  dwell_cnt_q;
      wire  lead_edge = l_in && !l_in_q;
      wire  trail_end = !t_in && t_in_q;
      wire  expire    = timed[g] && out_q && ms_tick &&
                        dwell_cnt_q == 16'h1;

      // Edges switch the output; dwell expiry may end it early
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          l_in_q      <= 1'b0;
          t_in_q      <= 1'b0;
          out_q       <= 1'b0;
          dwell_cnt_q <= 16'h0;
        end else begin
          l_in_q <= l_in;
          t_in_q <= t_in;
          if (lead_edge) begin
            out_q       <= 1'b1;
            dwell_cnt_q <= dwell_q[g];
          end else if (trail_end || expire) begin
            out_q       <= 1'b0;
          end else if (ms_tick && dwell_cnt_q != 16'h0) begin
            dwell_cnt_q <= dwell_cnt_q - 16'h1;
          end
        end
      end

      assign channel_out[g] = out_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Timed channel capacity check
  // ----------------------------------------------------------------
  // Each coarser time base step halves the channels it can service
  logic [7:0] timed_count;
  always_comb begin
    timed_count = 8'h0;
    for (int i = 0; i < NCH; i++) begin
      timed_count = timed_count + 8'(timed[i]);
    end
  end
  wire [7:0] tb_cap = 8'(NCH) >> dwell_time_base_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timed_output_overflow_error <= 1'b0;
    end else begin
      timed_output_overflow_error <= timed_count > tb_cap;
    end
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  wire [5:0] flat_now = 6'({program_bank_index_q[2:0] - 3'h1, 3'h0})
                        + 6'(in_bank_program_index_q - 4'h1);
  wire [DW-1:0] status = {timed_output_overflow_error, hw_active,
                          8'h0, active_program};
  wire [DW-1:0] chan_rd =
      !chan_ok            ? 16'h0 :
      page == PAGE_LEAD   ? lead_rd[chan_idx] :
      page == PAGE_TRAIL  ? trail_rd[chan_idx] :
                            dwell_q[chan_idx];
  wire [DW-1:0] rd_mux =
      req.addr == OFS_FLAT   ? 16'(flat_now) + 16'h1 :
      req.addr == OFS_BANK   ? 16'(program_bank_index_q) :
      req.addr == OFS_INDEX  ? 16'(in_bank_program_index_q) :
      req.addr == OFS_CTYPE  ? 16'(comp_type_select_q) :
      req.addr == OFS_TBASE  ? 16'(dwell_time_base_q) :
      req.addr == OFS_STATUS ? status :
      page != 2'h0           ? chan_rd : 16'h0;

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (rst || !req.rd) begin
      rdata_q <= 16'h0;
    end else begin
      rdata_q <= rd_mux;
    end
  end
  assign rdata = rdata_q;

endmodule

// ===== shared/cps_pkg.sv
// Purpose: Shared constants and carriers for the output timing block
// Assumes: 10 MHz ref_clk, plain register port with 16-bit data
// Notes:   Channel count and widths are module parameters in the top
package cps_pkg;

  // ----------------------------------------------------------------
  // Register port widths and offsets
  // ----------------------------------------------------------------
  localparam int AW = 8;
  localparam int DW = 16;
  localparam logic [AW-1:0] OFS_FLAT   = 8'h00;
  localparam logic [AW-1:0] OFS_BANK   = 8'h04;
  localparam logic [AW-1:0] OFS_INDEX  = 8'h08;
  localparam logic [AW-1:0] OFS_CTYPE  = 8'h0C;
  localparam logic [AW-1:0] OFS_TBASE  = 8'h10;
  localparam logic [AW-1:0] OFS_STATUS = 8'h14;
  localparam logic [AW-1:0] OFS_DECKEY = 8'h18;
  localparam logic [1:0]    PAGE_LEAD  = 2'h1;
  localparam logic [1:0]    PAGE_TRAIL = 2'h2;
  localparam logic [1:0]    PAGE_DWELL = 2'h3;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int NEG_BIT      = 15;
  localparam int DEC_TRAIL    = 7;
  localparam int ST_ERR_BIT   = 15;
  localparam int ST_HW_BIT    = 14;
  localparam logic [3:0] RST_BANK  = 4'h1;
  localparam logic [3:0] RST_INDEX = 4'h1;

  // ----------------------------------------------------------------
  // Timing and scaling
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam longint COMP_RPM_UNIT = 1000;
  localparam longint DEG_PER_REV   = 360;

  // Compensation type
  typedef enum logic {CPS_COMP_ONE, CPS_COMP_BOTH} cps_ctype_t;

  // Register port request
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } cps_req_t;

  // Serial port program change
  typedef struct packed {
    logic       wr;
    logic       sel_bank;
    logic [3:0] value;
  } cps_ser_t;

endpackage

// ===== test/cps_output_timing_monitor.sv
// Purpose: Port checker for the output timing block
// Assumes: One clock, rst synchronous active high
// Notes:   Select pins reach active_program three edges late
`timescale 1ns/1ns

module cps_output_timing_monitor
  import cps_pkg::*;
#(
  parameter int NCH  = 8,
  parameter int POSW = 14,
  parameter int RPMW = 14
) (
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire cps_pkg::cps_req_t     req,
  input wire logic [cps_pkg::DW-1:0] rdata,
  input wire cps_pkg::cps_ser_t     ser,
  input wire logic [2:0]            prog_sel_pins,
  input wire logic [POSW-1:0]       position,
  input wire logic [RPMW-1:0]       rpm,
  input wire logic [NCH*POSW-1:0]   on_setpoint,
  input wire logic [NCH*POSW-1:0]   off_setpoint,
  input wire logic [5:0]            active_program,
  input wire logic [NCH-1:0]        channel_out,
  input wire logic                  timed_output_overflow_error
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Helper terms
  // ----------------------------------------------------------------
  logic [2:0] off_hist_q;
  wire logic idle = !req.wr && !ser.wr;
  wire logic pins_off = prog_sel_pins == 3'h0;
  wire logic flat_wr = req.wr && req.addr == OFS_FLAT && pins_off
    && req.wdata inside {[16'h0001:16'h0040]} && &off_hist_q;
  wire logic [POSW-1:0] on0 = on_setpoint[POSW-1:0];
  wire logic [POSW-1:0] off0 = off_setpoint[POSW-1:0];
  wire logic out0 = rpm == '0 && on0 < off0
    && (position < on0 || position >= off0);

  // Pins quiet history; the sync stage can still carry an old code
  always_ff @(posedge ref_clk) off_hist_q <= {off_hist_q[1:0], pins_off};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_reset_clear: assert property (
    $fell(rst) |-> active_program == 6'h00 && channel_out == '0
    && !timed_output_overflow_error)
    else $error("outputs not cleared by reset");
  chk_flat_prog: assert property (
    flat_wr ##1 idle && pins_off
    |=> active_program == $past(req.wdata[5:0], 2) - 6'h01)
    else $error("flat number not selected");
  chk_pins_index: assert property (
    (!pins_off && $stable(prog_sel_pins))[*4]
    |-> active_program[2:0] == prog_sel_pins)
    else $error("select pins not used as index");
  chk_bank_kept: assert property (
    idle && $past(idle) |=> $stable(active_program[5:3]))
    else $error("bank moved without a write");
  chk_ser_bank: assert property (
    ser.wr && ser.sel_bank && !req.wr && ser.value inside {[4'h1:4'h8]}
    ##1 idle |=> active_program[5:3] == 3'($past(ser.value, 2) - 4'h1))
    else $error("serial bank change lost");
  chk_status_read: assert property (
    req.rd && req.addr == OFS_STATUS ##1 $stable(active_program)
    && $stable(timed_output_overflow_error)
    |-> rdata[5:0] == active_program
    && rdata[ST_ERR_BIT] == timed_output_overflow_error)
    else $error("status read mismatch");
  chk_window_off: assert property (
    out0 [*2] |=> !channel_out[0])
    else $error("channel on outside its window");
  chk_key_program: assert property (
    (pins_off && idle)[*5] |-> $stable(active_program))
    else $error("program moved with pins off");

  // Main scenarios reached
  cover property (flat_wr);
  cover property ($rose(timed_output_overflow_error));
  cover property (!pins_off ##4 active_program[2:0] == prog_sel_pins);
endmodule

bind cps_output_timing cps_output_timing_monitor #(
  .NCH(NCH), .POSW(POSW), .RPMW(RPMW)
) i_cps_output_timing_monitor (
  .ref_clk, .rst, .req, .rdata, .ser, .prog_sel_pins, .position, .rpm,
  .on_setpoint, .off_setpoint, .active_program, .channel_out,
  .timed_output_overflow_error
);

// ===== test/cps_field_model.sv
// Purpose: Field side model, a gating input that logs output edges
// Assumes: Outputs registered one cycle after the position sample
// Notes:   Only listens; the position logged is the one that caused it
`timescale 1ns/1ns

module cps_field_model #(
  parameter int NCH  = 2,
  parameter int POSW = 14
) (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic [NCH-1:0]  channel_out,
  input  wire logic [POSW-1:0] position,
  output logic [POSW-1:0]      on_pos [NCH],
  output logic [POSW-1:0]      off_pos [NCH],
  output logic [15:0]          on_len [NCH]
);
  logic [NCH-1:0]  out_q;
  logic [POSW-1:0] pos_q;
  logic [15:0]     run_q [NCH];

  // Edge log and pulse length per channel
  always_ff @(posedge ref_clk) begin
    out_q <= rst ? '0 : channel_out;
    pos_q <= position;
    for (int g = 0; g < NCH; g++) begin
      run_q[g] <= channel_out[g] ? run_q[g] + 16'h0001 : 16'h0000;
      if (channel_out[g] && !out_q[g]) on_pos[g] <= pos_q;
      if (!channel_out[g] && out_q[g]) begin
        off_pos[g] <= pos_q;
        on_len[g]  <= run_q[g];
      end
    end
  end
endmodule

// ===== test/cps_output_timing_bench.sv
// Purpose: Self-checking bench for the output timing block
// Assumes: 10 MHz ref_clk, one ms tick cut to 10 cycles
// Notes:   1000 RPM at 360 counts/rev shifts one count per comp unit
`timescale 1ns/1ns

module cps_output_timing_bench;
  import cps_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int NCH = 2;
  localparam int PW  = 14;
  localparam logic [7:0] LD0 = {PAGE_LEAD, 6'h00};
  localparam logic [7:0] LD1 = {PAGE_LEAD, 6'h04};
  localparam logic [7:0] TR0 = {PAGE_TRAIL, 6'h00};
  localparam logic [7:0] DL0 = {PAGE_DWELL, 6'h00};
  localparam logic [7:0] DL1 = {PAGE_DWELL, 6'h04};

  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  cps_req_t          req = '0;
  cps_ser_t          ser = '0;
  logic [2:0]        prog_sel_pins = 3'h0;
  logic [PW-1:0]     position = 14'h0000;
  logic [PW-1:0]     rpm = 14'h03E8;
  logic [NCH*PW-1:0] on_sp = {2{14'h0064}};
  logic [NCH*PW-1:0] off_sp = {2{14'h00C8}};
  logic [DW-1:0]     rdata;
  logic [5:0]        active_program;
  logic [NCH-1:0]    channel_out;
  logic              ovf;
  logic [PW-1:0]     on_pos [NCH];
  logic [PW-1:0]     off_pos [NCH];
  logic [15:0]       on_len [NCH];
  int                err_total = 0;
  int                cmp_count = 0;
  int                cyc = 0;

  // Clock, and a cycle ceiling well above the planned run
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("timeout at cycle %0d", cyc);
      wrap_up();
    end
  end

  cps_output_timing #(.NCH(NCH), .POSW(PW), .RPMW(PW), .MS_COUNT(10))
  i_cps_output_timing (
    .ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata), .ser(ser),
    .prog_sel_pins(prog_sel_pins), .position(position),
    .scale_factor(14'h0168), .rpm(rpm), .on_setpoint(on_sp),
    .off_setpoint(off_sp), .active_program(active_program),
    .channel_out(channel_out), .timed_output_overflow_error(ovf));

  cps_field_model #(.NCH(NCH), .POSW(PW)) i_cps_field_model (
    .ref_clk(ref_clk), .rst(rst), .channel_out(channel_out),
    .position(position), .on_pos(on_pos), .off_pos(off_pos),
    .on_len(on_len));

  // ----------------------------------------------------------------
  // Bus, compare and stimulus tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic cmp_val(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask

  // Strobe for one cycle, then one idle cycle
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    req.wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic chk_rd(input logic [7:0] a, input logic [15:0] exp);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    @(negedge ref_clk);
    cmp_val($sformatf("register %h", a), exp, rdata);
    @(posedge ref_clk);
  endtask

  task automatic ser_put(input logic b, input logic [3:0] v);
    ser <= '{wr: 1'b1, sel_bank: b, value: v};
    @(posedge ref_clk);
    ser.wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic sweep();
    for (int p = 0; p < 260; p++) begin
      position <= 14'(p);
      @(posedge ref_clk);
    end
    tick(3);
  endtask

  task automatic edges(input logic [15:0] a0, b0, a1, b1);
    cmp_val("on edge 0", a0, 16'(on_pos[0]));
    cmp_val("off edge 0", b0, 16'(off_pos[0]));
    cmp_val("on edge 1", a1, 16'(on_pos[1]));
    cmp_val("off edge 1", b1, 16'(off_pos[1]));
  endtask

  task automatic pulse();
    position <= 14'h0000;
    tick(3);
    position <= 14'h0096;
    tick(70);
    position <= 14'h0000;
    tick(4);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_program();
    logic [7:0] fl [4] = '{8'h22, 8'h01, 8'h40, 8'h09};
    logic [7:0] n;
    chk_rd(OFS_BANK, 16'h0001);
    chk_rd(8'h3C, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      n = fl[i] - 8'h01;
      reg_wr(OFS_FLAT, {8'h00, fl[i]});
      tick(1);
      cmp_val("program", {8'h00, n}, 16'(active_program));
      chk_rd(OFS_BANK, {13'h0000, n[5:3]} + 16'h0001);
      chk_rd(OFS_INDEX, {13'h0000, n[2:0]} + 16'h0001);
    end
    reg_wr(OFS_FLAT, 16'h0041);
    chk_rd(OFS_FLAT, 16'h0009);
    ser_put(1'b1, 4'h3);
    ser_put(1'b0, 4'h7);
    ser_put(1'b1, 4'h9);
    cmp_val("serial program", 16'h0016, 16'(active_program));
    $display("test program select done");
  endtask

  task automatic t_pins();
    reg_wr(OFS_FLAT, 16'h002A);
    reg_wr(OFS_INDEX, 16'h0001);
    for (int k = 1; k < 8; k++) begin
      prog_sel_pins <= 3'(k);
      tick(5);
      cmp_val("pin prog", 16'h0028 + 16'(k), 16'(active_program));
    end
    chk_rd(OFS_BANK, 16'h0006);
    prog_sel_pins <= 3'h0;
    reg_wr(OFS_INDEX, 16'h0005);
    tick(4);
    cmp_val("key program", 16'h002C, 16'(active_program));
    $display("test select pins done");
  endtask

  task automatic t_comp();
    reg_wr(LD1, 16'h0005);
    reg_wr(OFS_DECKEY, 16'h0001);
    chk_rd(LD1, 16'h0004);
    reg_wr(LD1, 16'h0000);
    reg_wr(OFS_DECKEY, 16'h0001);
    chk_rd(LD1, 16'h8001);
    reg_wr(LD1, 16'h0014);
    chk_rd(LD1, 16'h8014);
    reg_wr(LD0, 16'h000A);
    reg_wr(TR0, 16'h001E);
    sweep();
    edges(16'h005A, 16'h00BE, 16'h0078, 16'h00DC);
    reg_wr(OFS_CTYPE, 16'h0001);
    reg_wr(OFS_FLAT, 16'h0011);
    rpm <= 14'h07D0;
    sweep();
    edges(16'h0050, 16'h008C, 16'h008C, 16'h00C8);
    $display("test compensation done");
  endtask

  task automatic t_dwell();
    reg_wr(OFS_CTYPE, 16'h0000);
    rpm <= 14'h03E8;
    reg_wr(DL0, 16'h0003);
    reg_wr(DL1, 16'h0005);
    pulse();
    cmp_val("dwell 0", 1'h1, 16'(on_len[0] inside {[8'h13:8'h20]}));
    cmp_val("dwell 1", 1'h1, 16'(on_len[1] inside {[8'h27:8'h34]}));
    chk_rd(OFS_STATUS, 16'h0010);
    reg_wr(OFS_TBASE, 16'h0001);
    chk_rd(OFS_STATUS, 16'h8010);
    cmp_val("overflow", 16'h0001, 16'(ovf));
    reg_wr(DL0, 16'h0000);
    rpm <= 14'h0000;
    pulse();
    cmp_val("untimed", 16'h0046, on_len[0]);
    chk_rd(OFS_STATUS, 16'h0010);
    $display("test timed outputs done");
  endtask

  // Main sequence
  initial begin
    tick(12);
    rst <= 1'b0;
    t_program();
    t_pins();
    t_comp();
    t_dwell();
    wrap_up();
  end
endmodule
